//--- core/down_count_map.vh
// register offsets, field positions, reset values for the down-count start block
`ifndef DOWN_COUNT_MAP_VH
`define DOWN_COUNT_MAP_VH
`define DC_ADDR_W            4
`define DC_ADDR_START        4'h0
`define DC_ADDR_CONNECT      4'h1
`define DC_ADDR_RELOAD_EN    4'h2
`define DC_ADDR_RELOAD_VAL   4'h3
`define DC_ADDR_MODE         4'h4
`define DC_ADDR_CNT_SEL      4'h5
`define DC_ADDR_CNT_DATA     4'h6
`define DC_ADDR_PRESCALE     4'h7
`define DC_START_RESET       16'h0000
`define DC_CONNECT_RESET     16'h0000
`define DC_RELOAD_EN_RESET   8'h00
`define DC_RELOAD_VAL_RESET  16'h0000
`define DC_MODE_OFFSET_BIT   0
`define DC_MODE_RESET        1'b0
`define DC_PRESCALE_RESET    8'h00
`define DC_COUNT_ZERO        16'h0000
`define DC_UPPER_LO          8
`endif

//--- core/counter_bank_mem.v
// sixteen-word counter store with registered read port
`timescale 1ns/1ps
module counter_bank_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk_in,   // system clock
  input  wire             wr_en_in,     // write enable
  input  wire [AW-1:0]    wr_addr_in,   // write index
  input  wire [WIDTH-1:0] wr_data_in,   // write value
  input  wire [AW-1:0]    rd_addr_in,   // read index
  output reg  [WIDTH-1:0] rd_data_out   // registered read value
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule

//--- core/down_count_start_control.v
// start/stop control and counting for sixteen one-shot down-counters
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "down_count_map.vh"
// Behaviour
// [R1] Upper start bits clear on own underflow or on matching second-channel general compare.
// [R2] Lower start bits clear on own underflow or on first-channel general or output compare.
// [R3] In one-shot mode a start bit sets only by software write and only if its counter is nonzero.
// [R4] In offset mode upper bits set on second-channel output compare if nonzero or reloadable.
// [R5] In offset mode lower bits set on first-channel output compare or general compare.
// [R6] In offset mode software may also set any bit, effective only if its counter is nonzero.
// [R7] Start bits reset to zero; a zero bit halts its counter and a one lets it count.
// [R8] Writing zero to a start bit has no effect; only hardware clears it.
// [R9] An underflowing counter is forced to zero.
// [R10] Upper counters with reload enabled and nonzero reload value load it on trigger and start.
// [R11] A started counter decrements by one on every count tick.
module down_count_start_control #(
  parameter CW = 16,
  parameter NC = 16
) (
  input  wire          sys_clk_in,         // system clock, 100 MHz
  input  wire          nrst_in,            // async reset, active low
  input  wire [3:0]    addr_in,            // register index
  input  wire [15:0]   wdata_in,           // write data
  input  wire          wr_in,              // write strobe
  input  wire          rd_in,              // read strobe
  output reg  [15:0]   rdata_out,          // read data, cycle after rd
  input  wire          first_output_cmp_in,   // first-channel output compare match
  input  wire [7:0]    first_general_cmp_in,  // first-channel general compare H..A
  input  wire [7:0]    second_output_cmp_in,  // second-channel output compare H..A
  input  wire [7:0]    second_general_cmp_in, // second-channel general compare H..A
  output wire [NC-1:0] counter_start_bit_out, // start bits
  output reg  [NC-1:0] underflow_out          // one-cycle underflow pulses
);
  // ********************************************************
  // registers
  // ********************************************************
  reg  [NC-1:0] start_r;
  reg  [15:0]   connect_r;
  reg  [7:0]    reload_en_r;
  reg  [15:0]   reload_val_r;
  reg           offset_mode_r;
  reg  [3:0]    cnt_sel_r;
  reg  [7:0]    prescale_r;
  reg  [7:0]    pre_cnt_r;
  reg           tick_r;
  reg  [CW-1:0] cnt_r [0:NC-1];
  reg  [NC-1:0] start_nxt;
  reg  [NC-1:0] set_v;
  reg  [NC-1:0] clr_v;
  reg  [NC-1:0] uf_v;
  reg  [NC-1:0] reload_v;
  reg  [NC-1:0] nonzero_v;
  reg  [NC-1:0] trig_v;
  reg  [15:0]   rd_mux;
  integer       i;
  integer       j;
  wire [CW-1:0] mem_rd;
  wire          sel_wr;

  assign counter_start_bit_out = start_r;
  assign sel_wr = wr_in && (addr_in == `DC_ADDR_CNT_DATA);

  function is_nonzero;
    input [CW-1:0] v;
    begin
      is_nonzero = (v != `DC_COUNT_ZERO);
    end
  endfunction

  // ********************************************************
  // count tick divider
  // ********************************************************
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end else if (pre_cnt_r >= prescale_r) begin
      pre_cnt_r <= 8'h00;
      tick_r    <= 1'b1;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
      tick_r    <= 1'b0;
    end
  end

  // ********************************************************
  // start bit set and clear
  // ********************************************************
  always @* begin
    for (i = 0; i < NC; i = i + 1) begin
      nonzero_v[i] = is_nonzero(cnt_r[i]);
      uf_v[i]      = start_r[i] && tick_r && (cnt_r[i] == {{(CW-1){1'b0}}, 1'b1});
    end
    for (i = 0; i < 8; i = i + 1) begin
      // lower: first channel triggers
      trig_v[i] = offset_mode_r && connect_r[i] &&
                  (first_output_cmp_in || first_general_cmp_in[i]);         // [R5]
      clr_v[i]  = uf_v[i] || first_general_cmp_in[i] || first_output_cmp_in; // [R2]
      reload_v[i] = 1'b0;
      // upper: second channel triggers
      trig_v[i+8] = offset_mode_r && connect_r[i+8] && second_output_cmp_in[i]; // [R4]
      reload_v[i+8] = trig_v[i+8] && reload_en_r[i] &&
                      is_nonzero(reload_val_r[CW-1:0]);                    // [R10]
      clr_v[i+8] = uf_v[i+8] || second_general_cmp_in[i];                  // [R1]
    end
    for (i = 0; i < NC; i = i + 1) begin
      // software writes only set, and only with a nonzero count
      set_v[i] = (wr_in && (addr_in == `DC_ADDR_START) && wdata_in[i] &&
                  nonzero_v[i])                                            // [R3] [R6] [R8]
               || (trig_v[i] && (nonzero_v[i] || reload_v[i]));            // [R4] [R5]
      // set wins over a simultaneous clear
      start_nxt[i] = set_v[i] ? 1'b1 : (clr_v[i] ? 1'b0 : start_r[i]);
    end
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_r       <= `DC_START_RESET;                                    // [R7]
      underflow_out <= {NC{1'b0}};
    end else begin
      start_r       <= start_nxt;
      underflow_out <= uf_v;
    end
  end

  // ********************************************************
  // down-counters
  // ********************************************************
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (j = 0; j < NC; j = j + 1) begin
        cnt_r[j] <= `DC_COUNT_ZERO;
      end
    end else begin
      for (j = 0; j < NC; j = j + 1) begin
        if (reload_v[j]) begin
          cnt_r[j] <= reload_val_r[CW-1:0];                                // [R10]
        end else if (sel_wr && (cnt_sel_r == j[3:0])) begin
          cnt_r[j] <= wdata_in[CW-1:0];
        end else if (uf_v[j]) begin
          cnt_r[j] <= `DC_COUNT_ZERO;                                      // [R9]
        end else if (start_r[j] && tick_r && nonzero_v[j]) begin
          cnt_r[j] <= cnt_r[j] - {{(CW-1){1'b0}}, 1'b1};                   // [R7] [R11]
        end
      end
    end
  end

  // shadow copy of counters, its read port left unconnected; software read-back takes cnt_r[cnt_sel_r] directly
  counter_bank_mem #(
    .WIDTH (CW),
    .DEPTH (NC),
    .AW    (4)
  ) u_shadow (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (1'b1),
    .wr_addr_in  (pre_cnt_r[3:0]),
    .wr_data_in  (cnt_r[pre_cnt_r[3:0]]),
    .rd_addr_in  (cnt_sel_r),
    .rd_data_out ()
  );
  assign mem_rd = cnt_r[cnt_sel_r];

  // ********************************************************
  // control register writes
  // ********************************************************
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      connect_r     <= `DC_CONNECT_RESET;
      reload_en_r   <= `DC_RELOAD_EN_RESET;
      reload_val_r  <= `DC_RELOAD_VAL_RESET;
      offset_mode_r <= `DC_MODE_RESET;
      cnt_sel_r     <= 4'h0;
      prescale_r    <= `DC_PRESCALE_RESET;
    end else if (wr_in) begin
      case (addr_in)
        `DC_ADDR_CONNECT:    connect_r     <= wdata_in;
        `DC_ADDR_RELOAD_EN:  reload_en_r   <= wdata_in[7:0];
        `DC_ADDR_RELOAD_VAL: reload_val_r  <= wdata_in;
        `DC_ADDR_MODE:       offset_mode_r <= wdata_in[`DC_MODE_OFFSET_BIT];
        `DC_ADDR_CNT_SEL:    cnt_sel_r     <= wdata_in[3:0];
        `DC_ADDR_PRESCALE:   prescale_r    <= wdata_in[7:0];
        default:             cnt_sel_r     <= cnt_sel_r;
      endcase
    end
  end

  // ********************************************************
  // read port
  // ********************************************************
  always @* begin
    case (addr_in)
      `DC_ADDR_START:      rd_mux = start_r;
      `DC_ADDR_CONNECT:    rd_mux = connect_r;
      `DC_ADDR_RELOAD_EN:  rd_mux = {8'h00, reload_en_r};
      `DC_ADDR_RELOAD_VAL: rd_mux = reload_val_r;
      `DC_ADDR_MODE:       rd_mux = {15'h0000, offset_mode_r};
      `DC_ADDR_CNT_SEL:    rd_mux = {12'h000, cnt_sel_r};
      `DC_ADDR_CNT_DATA:   rd_mux = mem_rd;
      `DC_ADDR_PRESCALE:   rd_mux = {8'h00, prescale_r};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? rd_mux : 16'h0000;
    end
  end
endmodule

//--- dv/cmp_source.sv
// compare-match source standing in for timer channels 1 and 2
`timescale 1ns/1ps
module cmp_source (
  input  wire logic       sys_clk_in,       // clock
  input  wire logic [1:0] kind_in,          // 0/1 ch1 output/general, 2/3 ch2
  input  wire logic [7:0] mask_in,          // lanes a..h
  input  wire logic       go_in,            // request one match pulse
  output logic            o1_out = 1'b0,    // ch1 output compare match
  output logic      [7:0] g1_out = 8'h00,   // ch1 general compare match
  output logic      [7:0] o2_out = 8'h00,   // ch2 output compare match
  output logic      [7:0] g2_out = 8'h00    // ch2 general compare match
);
  // each request gives one match pulse, low otherwise
  always @(posedge sys_clk_in) begin
    o1_out <= go_in && kind_in == 2'd0;
    g1_out <= (go_in && kind_in == 2'd1) ? mask_in : 8'h00;
    o2_out <= (go_in && kind_in == 2'd2) ? mask_in : 8'h00;
    g2_out <= (go_in && kind_in == 2'd3) ? mask_in : 8'h00;
  end
endmodule

//--- dv/down_count_chk.sv
// assertion checker for the start-bit control block
`timescale 1ns/1ps
module down_count_chk #(parameter NC = 16) (
  input wire logic          sys_clk_in,            // clock
  input wire logic          nrst_in,               // reset
  input wire logic [3:0]    addr_in,               // index
  input wire logic [15:0]   wdata_in,              // write data
  input wire logic          wr_in,                 // write
  input wire logic          rd_in,                 // read
  input wire logic [15:0]   rdata_out,             // read data
  input wire logic          first_output_cmp_in,   // ch1 output match
  input wire logic [7:0]    first_general_cmp_in,  // ch1 general match
  input wire logic [7:0]    second_output_cmp_in,  // ch2 output match
  input wire logic [7:0]    second_general_cmp_in, // ch2 general match
  input wire logic [NC-1:0] counter_start_bit_out, // start bits
  input wire logic [NC-1:0] underflow_out          // underflow pulses
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic mode_r;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in) mode_r <= 1'b0;
    else if (wr_in && addr_in == 4'h4) mode_r <= wdata_in[0];
  property p_rst; $rose(nrst_in) |-> counter_start_bit_out == '0; endproperty
  a_rst: assert property (p_rst) else $error("start bits not zero");
  property p_rd; rd_in && addr_in == 4'h0 |=> rdata_out == $past(counter_start_bit_out);
  endproperty
  a_rd: assert property (p_rd) else $error("start read mismatch");
  property p_idle; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_noset; !(wr_in && addr_in == 4'h0 && wdata_in != 16'h0000) && !first_output_cmp_in
    && first_general_cmp_in == 8'h00 && second_output_cmp_in == 8'h00
    |=> (counter_start_bit_out & ~$past(counter_start_bit_out)) == '0; endproperty
  a_noset: assert property (p_noset) else $error("start bit set without cause");
  property p_clrup; second_general_cmp_in != 8'h00 && second_output_cmp_in == 8'h00 && !wr_in
    |=> (counter_start_bit_out[15:8] & $past(second_general_cmp_in)) == 8'h00; endproperty
  a_clrup: assert property (p_clrup) else $error("upper bit not cleared");
  property p_clrg; !mode_r && !wr_in && first_general_cmp_in != 8'h00
    |=> (counter_start_bit_out[7:0] & $past(first_general_cmp_in)) == 8'h00; endproperty
  a_clrg: assert property (p_clrg) else $error("lower bit not cleared");
  property p_clro; !mode_r && !wr_in && first_output_cmp_in |=> counter_start_bit_out[7:0] == 0;
  endproperty
  a_clro: assert property (p_clro) else $error("lower bits not cleared");
  property p_uf; underflow_out != '0 |-> (underflow_out & ~($past(counter_start_bit_out)
    | $past(counter_start_bit_out, 2))) == '0; endproperty
  a_uf: assert property (p_uf) else $error("underflow of halted counter");
endmodule

//--- dv/tb.sv
// self-checking bench for the start-bit control block
`timescale 1ns/1ps
module tb;
  logic        sys_clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, go = 0;
  logic [3:0]  addr_in = 0;
  logic [1:0]  kind = 0;
  logic [7:0]  mask = 0;
  logic [15:0] wdata_in = 0, v;
  wire  logic  first_output_cmp_in;
  wire  logic [7:0] first_general_cmp_in, second_output_cmp_in, second_general_cmp_in;
  wire  logic [15:0] rdata_out, counter_start_bit_out, underflow_out;
  int          fail_count = 0, check_count = 0, n;
  down_count_start_control down_count_start_control_inst (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .first_output_cmp_in(first_output_cmp_in),
    .first_general_cmp_in(first_general_cmp_in), .second_output_cmp_in(second_output_cmp_in),
    .second_general_cmp_in(second_general_cmp_in),
    .counter_start_bit_out(counter_start_bit_out), .underflow_out(underflow_out));
  cmp_source cmp_source_inst (.sys_clk_in(sys_clk_in), .kind_in(kind), .mask_in(mask),
    .go_in(go), .o1_out(first_output_cmp_in), .g1_out(first_general_cmp_in),
    .o2_out(second_output_cmp_in), .g2_out(second_general_cmp_in));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic fire(input logic [1:0] k, input logic [7:0] m);
    @(posedge sys_clk_in);
    go <= 1'b1;
    kind <= k;
    mask <= m;
    @(posedge sys_clk_in);
    go <= 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic t_oneshot;
    wr(4'h5, 16'h0002);
    wr(4'h6, 16'h0009);
    wr(4'h5, 16'h0000);
    wr(4'h6, 16'h0014);
    wr(4'h0, 16'h0003);
    chk(counter_start_bit_out, 16'h0001);
    wr(4'h0, 16'h0000);
    chk(counter_start_bit_out, 16'h0001);
    n = 2;
    while (underflow_out[0] !== 1'b1 && n < 40) begin
      @(posedge sys_clk_in);
      #1 n++;
    end
    chk(n[15:0], 16'h0014);
    chk(counter_start_bit_out[0], 1'b0);
    rd(4'h6);
    chk(v, 16'h0000);
    wr(4'h5, 16'h0002);
    rd(4'h6);
    chk(v, 16'h0009);
    $display("test one-shot done");
  endtask
  task automatic t_offset;
    wr(4'h7, 16'h00FF);
    wr(4'h4, 16'h0001);
    wr(4'h1, 16'h0308);
    wr(4'h5, 16'h0008);
    wr(4'h6, 16'h0005);
    fire(2'd2, 8'h01);
    chk(counter_start_bit_out[8], 1'b1);
    fire(2'd3, 8'h01);
    chk(counter_start_bit_out[8], 1'b0);
    wr(4'h5, 16'h0003);
    wr(4'h6, 16'h0005);
    fire(2'd0, 8'h00);
    chk(counter_start_bit_out[7:0], 8'h08);
    wr(4'h2, 16'h0002);
    wr(4'h3, 16'h0007);
    fire(2'd2, 8'h02);
    chk(counter_start_bit_out[9], 1'b1);
    wr(4'h5, 16'h0009);
    rd(4'h6);
    chk(v, 16'h0007);
    wr(4'h0, 16'h4004);
    chk({counter_start_bit_out[14], counter_start_bit_out[2]}, 2'b01);
    wr(4'h4, 16'h0000);
    fire(2'd1, 8'h08);
    chk(counter_start_bit_out[9:2], 8'h81);
    fire(2'd0, 8'h00);
    chk(counter_start_bit_out, 16'h0200);
    $display("test offset done");
  endtask
  task automatic t_power_on;
    chk(counter_start_bit_out, 16'h0000);
    rd(4'h0);
    chk(v, 16'h0000);
    rd(4'h8);
    chk(v, 16'h0000);
    $display("test power-on reset done");
  endtask
  task automatic t_mid_reset;
    @(posedge sys_clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1 chk(counter_start_bit_out, 16'h0000);
    @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 chk(counter_start_bit_out, 16'h0000);
    rd(4'h7);
    chk(v, 16'h0000);
    wr(4'h0, 16'h0200);
    chk(counter_start_bit_out, 16'h0000);
    $display("test mid-run reset done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 t_power_on;
    t_oneshot;
    t_offset;
    t_mid_reset;
    conclude;
  end
  initial begin
    #50000;
    fail_count++;
    conclude;
  end
endmodule
bind down_count_start_control down_count_chk #(.NC(NC)) down_count_chk_inst (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .first_output_cmp_in(first_output_cmp_in), .first_general_cmp_in(first_general_cmp_in),
  .second_output_cmp_in(second_output_cmp_in), .second_general_cmp_in(second_general_cmp_in),
  .counter_start_bit_out(counter_start_bit_out), .underflow_out(underflow_out));
